/* File: rtl/blp_cfg.svh */
// timing constants and rule summary for the button and led panel
// Summary of operation
// [R1] key lock is on after reset; only the unlock sequence is accepted while locked
// [R2] reset press followed by learn press within 2 s releases the key lock
// [R3] successful unlock flashes the key-press led as confirmation
// [R4] 2 minutes after unlocking the lock re-engages and the key-press led goes off
// [R5] permission inputs select which button actions may execute
// [R6] reset alone held over 2 s while unlocked clears alarms
// [R7] reset alone held over 10 s while unlocked restarts instead
// [R8] learn held over 5 s while unlocked restarts learning mode
// [R9] reset and learn pressed together trigger factory default restore
// [R10] factory restore needs start-up complete and both held over 10 s
// [R11] unlocked: key-press led green while either button is touched
// [R12] until start-up completes the status led alternates red and yellow
// [R13] start-up completion steps status led flashing red, yellow, green
// [R14] after start-up: green ready, yellow pre-alarm, red main alarm
// [R15] status led flashes green while any value is still learning
// [R16] maintenance, firmware reset, update or restart alternate red and yellow
// [R17] alarm display suppression survives ordinary reset; factory restore re-enables it
// [R18] network link led blue while link up, flashing during traffic
// [R19] serial-network led blue while connected, flashing during data exchange
// [R20] operator should press buttons only after start-up completes
// [R21] hold measured from onset; one action of longest exceeded threshold per press
`ifndef BLP_CFG_SVH
`define BLP_CFG_SVH

`define BLP_CNT_W 36
`define BLP_CLK_HZ 64'h000000000EE6B280
`define BLP_MS_PER_S 64'h00000000000003E8
`define BLP_UNLOCK_WIN_S 64'h0000000000000002
`define BLP_RELOCK_S 64'h0000000000000078
`define BLP_CLEAR_HOLD_S 64'h0000000000000002
`define BLP_RESTART_HOLD_S 64'h000000000000000A
`define BLP_LEARN_HOLD_S 64'h0000000000000005
`define BLP_FACTORY_HOLD_S 64'h000000000000000A
`define BLP_BLINK_HALF_MS 64'h00000000000000FA
`define BLP_CONFIRM_MS 64'h00000000000003E8
`define BLP_SEQ_STEP_MS 64'h00000000000003E8
`define BLP_SEQ_LAST 2'h2

`endif

/* File: rtl/blp_pkg.sv */
// types shared by the button and led panel
package blp_pkg;
   typedef logic [35:0] blp_cnt_t;
   typedef enum logic [2:0] {
      BLP_LOCKED = 3'h1,
      BLP_ARMED = 3'h2,
      BLP_OPEN = 3'h4
   } blp_lock_e;
   typedef enum logic [1:0] {
      BLP_IDLE = 2'h1,
      BLP_HOLD = 2'h2
   } blp_press_e;
   typedef enum logic [2:0] {
      BLP_BOOT = 3'h1,
      BLP_SEQ = 3'h2,
      BLP_RUN = 3'h4
   } blp_boot_e;
endpackage

/* File: rtl/blp_sync.sv */
// two-flop synchroniser for the two button pins
module blp_sync (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] pin_in,
   output logic [1:0] sync_out
);
   logic [1:0] meta_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 2'h0;
         sync_out <= 2'h0;
      end else begin
         meta_q <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule

/* File: rtl/blp_panel.sv */
// front-panel button decoder, key lock and led driver
`include "blp_cfg.svh"
module blp_panel #(
   parameter blp_pkg::blp_cnt_t UNLOCK_WIN_CYC = 36'(`BLP_UNLOCK_WIN_S * `BLP_CLK_HZ),
   parameter blp_pkg::blp_cnt_t RELOCK_CYC = 36'(`BLP_RELOCK_S * `BLP_CLK_HZ),
   parameter blp_pkg::blp_cnt_t CLEAR_CYC = 36'(`BLP_CLEAR_HOLD_S * `BLP_CLK_HZ),
   parameter blp_pkg::blp_cnt_t RESTART_CYC = 36'(`BLP_RESTART_HOLD_S * `BLP_CLK_HZ),
   parameter blp_pkg::blp_cnt_t LEARN_CYC = 36'(`BLP_LEARN_HOLD_S * `BLP_CLK_HZ),
   parameter blp_pkg::blp_cnt_t FACTORY_CYC = 36'(`BLP_FACTORY_HOLD_S * `BLP_CLK_HZ),
   parameter blp_pkg::blp_cnt_t BLINK_HALF_CYC =
      36'(`BLP_BLINK_HALF_MS * `BLP_CLK_HZ / `BLP_MS_PER_S),
   parameter blp_pkg::blp_cnt_t CONFIRM_CYC = 36'(`BLP_CONFIRM_MS * `BLP_CLK_HZ / `BLP_MS_PER_S),
   parameter blp_pkg::blp_cnt_t SEQ_STEP_CYC =
      36'(`BLP_SEQ_STEP_MS * `BLP_CLK_HZ / `BLP_MS_PER_S)
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic btn_reset_pin,
   input wire logic btn_learn_pin,
   input wire logic startup_done,
   input wire logic maint_mode,
   input wire logic fw_busy,
   input wire logic alarm_pre,
   input wire logic alarm_main,
   input wire logic learning_active,
   input wire logic link_up,
   input wire logic link_activity,
   input wire logic serial_up,
   input wire logic serial_activity,
   input wire logic perm_clear_alarm,
   input wire logic perm_restart,
   input wire logic perm_learn,
   input wire logic perm_factory,
   input wire logic cfg_hide_wr,
   input wire logic cfg_hide_val,
   output logic act_clear_alarm,
   output logic act_restart,
   output logic act_learn_restart,
   output logic act_factory,
   output logic status_red,
   output logic status_green,
   output logic network_link_led,
   output logic serial_led,
   output logic key_led,
   output logic key_unlocked,
   output logic alarm_hidden
);
   import blp_pkg::*;

   function automatic logic at_least(input blp_cnt_t cnt, input blp_cnt_t thr);
      at_least = (cnt >= thr);
   endfunction

   function automatic logic flash(input logic up, input logic busy, input logic ph);
      flash = up & ~(busy & ph);
   endfunction

   function automatic blp_cnt_t sat_inc(input blp_cnt_t cnt, input blp_cnt_t lim);
      sat_inc = (cnt >= lim) ? cnt : cnt + 36'h000000001;
   endfunction

   // button pins come from the panel, outside the clock domain
   logic [1:0] btn_s;
   blp_sync u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in({btn_learn_pin, btn_reset_pin}),
      .sync_out(btn_s)
   );

   logic [1:0] btn_prev_q;
   wire rst_s = btn_s[0];
   wire lrn_s = btn_s[1];
   wire any_s = rst_s | lrn_s;
   wire rst_rise = rst_s & ~btn_prev_q[0];
   wire lrn_rise = lrn_s & ~btn_prev_q[1];
   wire any_rise = any_s & ~(btn_prev_q[0] | btn_prev_q[1]);

   // shared blink phase for every flashing led
   blp_cnt_t blink_cnt_q;
   logic blink_q;
   wire blink_wrap = (blink_cnt_q == BLINK_HALF_CYC - 36'h000000001);
   wire period_end = blink_wrap & blink_q;

   // key lock
   blp_lock_e lock_q, lock_d;
   blp_cnt_t win_cnt_q, relock_cnt_q, confirm_cnt_q;
   logic unlocked_q;
   wire is_open = (lock_q == BLP_OPEN);
   wire win_done = (win_cnt_q >= UNLOCK_WIN_CYC - 36'h000000001);
   wire relock_done = (relock_cnt_q == RELOCK_CYC - 36'h000000001);
   wire confirm_act = (confirm_cnt_q != 36'h000000000);

   always_comb begin
      lock_d = lock_q;
      case (lock_q)
         BLP_LOCKED: begin
            if (rst_rise && !lrn_s) begin
               lock_d = BLP_ARMED; // R1
            end
         end
         BLP_ARMED: begin
            if (lrn_rise) begin
               lock_d = BLP_OPEN; // R2
            end else if (win_done) begin
               lock_d = BLP_LOCKED;
            end
         end
         BLP_OPEN: begin
            if (relock_done) begin
               lock_d = BLP_LOCKED; // R4
            end
         end
         default: lock_d = BLP_LOCKED;
      endcase
   end
   wire unlock_now = (lock_q != BLP_OPEN) && (lock_d == BLP_OPEN);

   // press measurement, only while unlocked
   blp_press_e press_q, press_d;
   blp_cnt_t hold_cnt_q;
   logic both_q, rst_seen_q, lrn_seen_q;
   wire released = (press_q == BLP_HOLD) && !any_s && is_open;
   wire both_any = both_q | (rst_s & lrn_s);

   always_comb begin
      press_d = press_q;
      case (press_q)
         BLP_IDLE: begin
            if (is_open && any_rise) begin
               press_d = BLP_HOLD; // R21
            end
         end
         BLP_HOLD: begin
            if (!is_open || !any_s) begin
               press_d = BLP_IDLE;
            end
         end
         default: press_d = BLP_IDLE;
      endcase
   end

   // longest exceeded threshold wins, decided once at release
   wire hold_restart = at_least(hold_cnt_q, RESTART_CYC);
   wire solo_rst = !both_q && rst_seen_q && !lrn_seen_q;
   wire solo_lrn = !both_q && lrn_seen_q && !rst_seen_q;
   wire fire_factory = released && both_q && at_least(hold_cnt_q, FACTORY_CYC)
                       && startup_done && perm_factory; // R9 R10 R5
   wire fire_restart = released && solo_rst && hold_restart && perm_restart; // R7 R5
   wire fire_clear = released && solo_rst && !hold_restart
                     && at_least(hold_cnt_q, CLEAR_CYC) && perm_clear_alarm; // R6 R5 R21
   wire fire_learn = released && solo_lrn && at_least(hold_cnt_q, LEARN_CYC)
                     && perm_learn; // R8 R5

   // start-up display sequence
   blp_boot_e boot_q, boot_d;
   blp_cnt_t seq_cnt_q;
   logic [1:0] step_q;
   wire step_done = (seq_cnt_q == SEQ_STEP_CYC - 36'h000000001);

   always_comb begin
      boot_d = boot_q;
      case (boot_q)
         BLP_BOOT: begin
            if (startup_done) begin
               boot_d = BLP_SEQ; // R13
            end
         end
         BLP_SEQ: begin
            if (step_done && step_q == `BLP_SEQ_LAST) begin
               boot_d = BLP_RUN;
            end
         end
         BLP_RUN: begin
            if (!startup_done) begin
               boot_d = BLP_BOOT;
            end
         end
         default: boot_d = BLP_BOOT;
      endcase
   end

   // status colour: red and green together make yellow
   logic red_d, green_d;
   logic hidden_q;
   wire alt_red_yel = maint_mode | fw_busy;
   always_comb begin
      red_d = 1'b1;
      green_d = blink_q;
      case (boot_q)
         BLP_BOOT: begin
            red_d = 1'b1; // R12
            green_d = blink_q;
         end
         BLP_SEQ: begin
            red_d = blink_q & (step_q != `BLP_SEQ_LAST); // R13
            green_d = blink_q & (step_q != 2'h0);
         end
         BLP_RUN: begin
            if (alt_red_yel) begin
               red_d = 1'b1; // R16
               green_d = blink_q;
            end else if (learning_active) begin
               red_d = 1'b0; // R15
               green_d = blink_q;
            end else if (hidden_q || !(alarm_main || alarm_pre)) begin
               red_d = 1'b0; // R14 R17
               green_d = 1'b1;
            end else begin
               red_d = 1'b1; // R14
               green_d = !alarm_main;
            end
         end
         default: begin
            red_d = 1'b1;
            green_d = blink_q;
         end
      endcase
   end

   // traffic stretch so one-cycle activity still shows a flash
   logic link_busy_q, serial_busy_q;
   wire link_busy_d = link_activity | (link_busy_q & ~period_end);
   wire serial_busy_d = serial_activity | (serial_busy_q & ~period_end);

   // suppression only reset by power-on or factory restore; a write wins
   wire hidden_d = cfg_hide_wr ? cfg_hide_val : (hidden_q & ~fire_factory); // R17

   wire key_led_d = is_open & (confirm_act ? blink_q : any_s); // R3 R11 R4

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         btn_prev_q <= 2'h0;
         blink_cnt_q <= 36'h000000000;
         blink_q <= 1'b0;
      end else begin
         btn_prev_q <= btn_s;
         blink_cnt_q <= blink_wrap ? 36'h000000000 : blink_cnt_q + 36'h000000001;
         blink_q <= blink_q ^ blink_wrap;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lock_q <= BLP_LOCKED; // R1
         unlocked_q <= 1'b0;
         win_cnt_q <= 36'h000000000;
         relock_cnt_q <= 36'h000000000;
         confirm_cnt_q <= 36'h000000000;
      end else begin
         lock_q <= lock_d;
         unlocked_q <= (lock_d == BLP_OPEN);
         win_cnt_q <= (lock_q == BLP_ARMED) ? win_cnt_q + 36'h000000001 : 36'h000000000;
         relock_cnt_q <= is_open ? relock_cnt_q + 36'h000000001 : 36'h000000000; // R4
         if (unlock_now) begin
            confirm_cnt_q <= CONFIRM_CYC; // R3
         end else if (confirm_act) begin
            confirm_cnt_q <= confirm_cnt_q - 36'h000000001;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         press_q <= BLP_IDLE;
         hold_cnt_q <= 36'h000000000;
         both_q <= 1'b0;
         rst_seen_q <= 1'b0;
         lrn_seen_q <= 1'b0;
      end else begin
         press_q <= press_d;
         if (press_q == BLP_IDLE) begin
            hold_cnt_q <= 36'h000000000; // R21
            both_q <= 1'b0;
            rst_seen_q <= 1'b0;
            lrn_seen_q <= 1'b0;
         end else begin
            // saturates so a very long hold still reads as the top threshold
            hold_cnt_q <= sat_inc(hold_cnt_q, RESTART_CYC | FACTORY_CYC);
            both_q <= both_any;
            rst_seen_q <= rst_seen_q | rst_s;
            lrn_seen_q <= lrn_seen_q | lrn_s;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         boot_q <= BLP_BOOT;
         seq_cnt_q <= 36'h000000000;
         step_q <= 2'h0;
      end else begin
         boot_q <= boot_d;
         if (boot_q != BLP_SEQ || step_done) begin
            seq_cnt_q <= 36'h000000000;
         end else begin
            seq_cnt_q <= seq_cnt_q + 36'h000000001;
         end
         if (boot_q != BLP_SEQ) begin
            step_q <= 2'h0;
         end else if (step_done) begin
            step_q <= step_q + 2'h1; // R13
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         act_clear_alarm <= 1'b0;
         act_restart <= 1'b0;
         act_learn_restart <= 1'b0;
         act_factory <= 1'b0;
         status_red <= 1'b0;
         status_green <= 1'b0;
         network_link_led <= 1'b0;
         serial_led <= 1'b0;
         key_led <= 1'b0;
         link_busy_q <= 1'b0;
         serial_busy_q <= 1'b0;
         hidden_q <= 1'b0;
      end else begin
         act_clear_alarm <= fire_clear;
         act_restart <= fire_restart;
         act_learn_restart <= fire_learn;
         act_factory <= fire_factory;
         status_red <= red_d;
         status_green <= green_d;
         link_busy_q <= link_busy_d;
         serial_busy_q <= serial_busy_d;
         network_link_led <= flash(link_up, link_busy_q, blink_q); // R18
         serial_led <= flash(serial_up, serial_busy_q, blink_q); // R19
         key_led <= key_led_d;
         hidden_q <= hidden_d;
      end
   end

   assign key_unlocked = unlocked_q;
   assign alarm_hidden = hidden_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   wire any_act = act_clear_alarm | act_restart | act_learn_restart | act_factory;
   a_locked_no_act: assert property (any_act |-> $past(unlocked_q)) // R1
      else $error("action issued while key lock engaged");
   a_unlock_seq: assert property ((lock_q == BLP_ARMED && lrn_rise) |=> unlocked_q) // R2
      else $error("unlock sequence did not release the lock");
   a_unlock_confirm: assert property ($rose(unlocked_q) |-> confirm_act) // R3
      else $error("unlock not confirmed by key led flash");
   a_auto_relock: assert property ((is_open && relock_done) |=> !unlocked_q ##1 !key_led) // R4
      else $error("lock did not re-engage or key led stayed on");
   a_perm_gate: assert property (act_restart |-> $past(perm_restart)) // R5
      else $error("restart issued without permission");
   a_single_act: assert property ($onehot0({act_clear_alarm, act_restart,
                                            act_learn_restart, act_factory})) // R21
      else $error("more than one action for one press");
   a_factory_ready: assert property (act_factory |-> $past(startup_done)) // R10
      else $error("factory restore before start-up completed");
   a_touch_led: assert property ((is_open && !confirm_act && any_s) |=> key_led) // R11
      else $error("key led not lit while touched");
   a_boot_red: assert property ((boot_q == BLP_BOOT) |=> status_red) // R12
      else $error("status led not red/yellow during start-up");
   a_hide_reenable: assert property ((act_factory && !$past(cfg_hide_wr)) |-> !alarm_hidden) // R17
      else $error("factory restore left alarm display suppressed");
   c_unlock: cover property ($rose(unlocked_q));
   c_clear: cover property (act_clear_alarm);
   c_factory: cover property (act_factory);
   c_relock: cover property ($fell(unlocked_q));
endmodule

/* File: verif/blp_operator.sv */
// behavioural operator touching the two panel buttons
module blp_operator (
   input wire logic core_clk,
   output logic btn_reset_pin,
   output logic btn_learn_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      btn_reset_pin = 1'h0;
      btn_learn_pin = 1'h0;
   end
   // contact changes only just after an edge, released pads read low
   task automatic touch(input logic r, input logic l);
      @(posedge core_clk);
      btn_reset_pin <= r;
      btn_learn_pin <= l;
   endtask
   // the bench calls this only once start-up has been seen to end
   task automatic hold(input logic r, input logic l, input int n);
      touch(r, l);
      repeat (n) @(posedge core_clk);
      touch(1'h0, 1'h0);
   endtask
   // reset first, learn after gap cycles, reset kept down meanwhile
   task automatic unlock_seq(input int gap);
      touch(1'h1, 1'h0);
      repeat (gap) @(posedge core_clk);
      touch(1'h1, 1'h1);
      repeat (3) @(posedge core_clk);
      touch(1'h0, 1'h0);
   endtask
endmodule

/* File: verif/blp_panel_bench.sv */
// self-checking bench for the button and led panel
module blp_panel_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WIN = 40, RLK = 400, CLR = 20, RST = 100, LRN = 50, FAC = 100;
   logic core_clk = 1'h0, rstn = 1'h0, startup_done = 1'h0;
   logic maint_mode = 1'h0, fw_busy = 1'h0, alarm_pre = 1'h0, alarm_main = 1'h0;
   logic learning_active = 1'h0, link_up = 1'h0, link_activity = 1'h0;
   logic serial_up = 1'h0, serial_activity = 1'h0, cfg_hide_wr = 1'h0, cfg_hide_val = 1'h0;
   logic perm_clear_alarm = 1'h1, perm_restart = 1'h1, perm_learn = 1'h1, perm_factory = 1'h1;
   logic btn_reset_pin, btn_learn_pin, act_clear_alarm, act_restart, act_learn_restart;
   logic act_factory, status_red, status_green, network_link_led, serial_led, key_led;
   logic key_unlocked, alarm_hidden, open_prev = 1'h0;
   int err_total = 0, checks_done = 0, cyc = 0, t_open = 0;
   wire logic [3:0] acts = {act_factory, act_learn_restart, act_restart, act_clear_alarm};
   always #2 core_clk = ~core_clk;
   blp_operator op (.core_clk, .btn_reset_pin, .btn_learn_pin);
   blp_panel #(.UNLOCK_WIN_CYC(36'(WIN)), .RELOCK_CYC(36'(RLK)), .CLEAR_CYC(36'(CLR)),
      .RESTART_CYC(36'(RST)), .LEARN_CYC(36'(LRN)), .FACTORY_CYC(36'(FAC)),
      .BLINK_HALF_CYC(36'h4), .CONFIRM_CYC(36'h10), .SEQ_STEP_CYC(36'h20)) dut (
      .core_clk, .rstn, .btn_reset_pin, .btn_learn_pin, .startup_done, .maint_mode,
      .fw_busy, .alarm_pre, .alarm_main, .learning_active, .link_up, .link_activity,
      .serial_up, .serial_activity, .perm_clear_alarm, .perm_restart, .perm_learn,
      .perm_factory, .cfg_hide_wr, .cfg_hide_val, .act_clear_alarm, .act_restart,
      .act_learn_restart, .act_factory, .status_red, .status_green, .network_link_led,
      .serial_led, .key_led, .key_unlocked, .alarm_hidden);
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // cycle count, unlock time stamp and hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      open_prev <= key_unlocked;
      if (key_unlocked === 1'h1 && open_prev !== 1'h1) t_open <= cyc;
      if (cyc > 30000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // actions fire after release, so the watch starts at release
   task automatic act_try(input logic r, input logic l, input int n, input logic [3:0] exp);
      logic [3:0] seen;
      int k;
      if (n > 0) op.hold(r, l, n);
      seen = 4'h0;
      k = 0;
      repeat (8) begin
         @(posedge core_clk);
         #1;
         seen |= acts;
         k += acts[0] + acts[1] + acts[2] + acts[3];
      end
      chk_vec(16'(seen), 16'(exp));
      chk_vec(16'(k), 16'(exp != 4'h0));
   endtask
   // mode 0 dark, 1 flashing, 2 steady over a 16 cycle look
   function automatic logic fits(input int c, input int m);
      return m == 0 ? c == 0 : (m == 2 ? c == 16 : (c > 0 && c < 16));
   endfunction
   task automatic led_case(input int mr, input int mg, input int lag);
      int rc, gc;
      rc = 0;
      gc = 0;
      repeat (lag) @(posedge core_clk);
      repeat (16) begin
         @(posedge core_clk);
         #1;
         rc += status_red;
         gc += status_green;
      end
      chk_bit(fits(rc, mr), 1'h1);
      chk_bit(fits(gc, mg), 1'h1);
   endtask
   task automatic unlock();
      op.unlock_seq(4);
      repeat (2) @(posedge core_clk);
      #1;
      chk_bit(key_unlocked, 1'h1);
   endtask
   task automatic t_status();
      led_case(2, 1, 0);
      @(posedge core_clk);
      startup_done <= 1'h1;
      led_case(1, 0, 8);
      led_case(1, 1, 16);
      led_case(0, 1, 16);
      led_case(0, 2, 16);
      @(posedge core_clk);
      alarm_pre <= 1'h1;
      led_case(2, 2, 3);
      @(posedge core_clk);
      alarm_main <= 1'h1;
      led_case(2, 0, 3);
      @(posedge core_clk);
      learning_active <= 1'h1;
      led_case(0, 1, 3);
      @(posedge core_clk);
      learning_active <= 1'h0;
      maint_mode <= 1'h1;
      led_case(2, 1, 3);
      @(posedge core_clk);
      maint_mode <= 1'h0;
      fw_busy <= 1'h1;
      led_case(2, 1, 3);
      @(posedge core_clk);
      fw_busy <= 1'h0;
      cfg_hide_val <= 1'h1;
      cfg_hide_wr <= 1'h1;
      @(posedge core_clk);
      cfg_hide_wr <= 1'h0;
      led_case(0, 2, 3);
      chk_bit(alarm_hidden, 1'h1);
   endtask
   task automatic t_links();
      int a, b;
      a = 0;
      b = 0;
      @(posedge core_clk);
      link_up <= 1'h1;
      serial_up <= 1'h1;
      repeat (3) @(posedge core_clk);
      #1;
      chk_bit(network_link_led, 1'h1);
      chk_bit(serial_led, 1'h1);
      @(posedge core_clk);
      link_activity <= 1'h1;
      serial_activity <= 1'h1;
      @(posedge core_clk);
      link_activity <= 1'h0;
      serial_activity <= 1'h0;
      repeat (12) begin
         @(posedge core_clk);
         #1;
         a += network_link_led;
         b += serial_led;
      end
      chk_bit(a > 0 && a < 12, 1'h1);
      chk_bit(b > 0 && b < 12, 1'h1);
   endtask
   // locked: holds do nothing, a late learn press does not unlock
   task automatic t_lock();
      act_try(1'h0, 1'h1, LRN + 10, 4'h0);
      act_try(1'h1, 1'h0, CLR + 10, 4'h0);
      repeat (WIN + 10) @(posedge core_clk);
      op.unlock_seq(WIN + 10);
      act_try(1'h0, 1'h0, 0, 4'h0);
      chk_bit(key_unlocked, 1'h0);
      repeat (WIN + 10) @(posedge core_clk);
   endtask
   task automatic t_actions();
      int n;
      n = 0;
      unlock();
      repeat (16) begin
         @(posedge core_clk);
         #1;
         n += key_led;
      end
      chk_bit(n > 0 && n < 16, 1'h1);
      op.touch(1'h0, 1'h1);
      repeat (4) @(posedge core_clk);
      #1;
      chk_bit(key_led, 1'h1);
      op.touch(1'h0, 1'h0);
      act_try(1'h0, 1'h0, 0, 4'h0);
      chk_bit(key_led, 1'h0);
      act_try(1'h1, 1'h0, CLR + 10, 4'h1);
      act_try(1'h1, 1'h0, RST + 10, 4'h2);
      chk_bit(alarm_hidden, 1'h1);
      act_try(1'h0, 1'h1, LRN + 10, 4'h4);
   endtask
   // power-on reset clears suppression; rewrite it, then factory restore and relock
   task automatic t_restore();
      int w, d;
      w = 0;
      @(posedge core_clk);
      rstn <= 1'h0;
      startup_done <= 1'h0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'h1;
      startup_done <= 1'h1;
      repeat (110) @(posedge core_clk);
      #1;
      chk_bit(alarm_hidden, 1'h0);
      chk_bit(key_unlocked, 1'h0);
      @(posedge core_clk);
      cfg_hide_wr <= 1'h1;
      @(posedge core_clk);
      cfg_hide_wr <= 1'h0;
      unlock();
      repeat (14) @(posedge core_clk);
      perm_clear_alarm <= 1'h0;
      perm_restart <= 1'h0;
      act_try(1'h1, 1'h0, CLR + 10, 4'h0);
      act_try(1'h1, 1'h0, RST + 10, 4'h0);
      act_try(1'h1, 1'h1, FAC / 2, 4'h0);
      act_try(1'h1, 1'h1, FAC + 10, 4'h8);
      chk_bit(alarm_hidden, 1'h0);
      while (key_unlocked === 1'h1 && w < 200) begin
         @(posedge core_clk);
         #1;
         w++;
      end
      d = cyc - t_open;
      chk_bit(d >= RLK - 2 && d <= RLK + 2, 1'h1);
      repeat (2) @(posedge core_clk);
      #1;
      chk_bit(key_led, 1'h0);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'h1;
      t_status();
      t_links();
      t_lock();
      t_actions();
      t_restore();
      conclude();
   end
endmodule
